// File: common/xcp_pkg.sv
// shared constants for the pin continuity chain and its test port
package xcp_pkg;
   localparam int          SYNC_STAGES   = 2;              // flops on every pin input
   localparam int          IR_LEN        = 4;              // instruction register width
   localparam int          ID_LEN        = 32;             // identification register width
   localparam logic [3:0]  IR_CAPTURE    = 4'h1;           // pattern loaded at Capture-IR
   localparam logic [3:0]  IR_IDCODE     = 4'h1;           // select identification register
   localparam logic [3:0]  IR_RST_TEST   = 4'h2;           // reset test register
   localparam logic [3:0]  IR_TEST4      = 4'hD;           // test register 4 (chain enable)
   localparam logic [3:0]  IR_BYPASS     = 4'hF;           // select bypass stage
   localparam int          CHAIN_EN_BIT  = 1;              // chain enable field position
   localparam logic [31:0] TEST4_RESET   = 32'h00000000;   // reset value of test registers
   localparam logic [11:0] END_MARKER    = 12'h0FF;        // reserved low twelve id bits
   localparam logic [31:0] TEST4_WMASK   = 32'h003FCF1F;   // writable bits of test register 4
   localparam logic [31:0] RST_TEST_WMASK = 32'h00FFE3FF;  // writable bits of reset test reg

   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
   } xcp_tap_type;
endpackage

// File: rtl/xcp_chain_test.sv
// pin continuity chain with its test access port
// Rules for this block, its tester and its host
// [RQ1] chain mode switched only through test register
// [RQ2] bit 1 of test register 4 enables
// [RQ3] chain mode detaches pins, uses them as inputs
// [RQ4] power, regulator, reference, reset, analog pins excluded
// [RQ5] result driven on dedicated result pin
// [RQ6] any single input change toggles output
// [RQ7] all inputs low gives high output
// [RQ8] output is inverted parity of all inputs
// [RQ9] tester raises inputs in descending order
// [RQ10] tester lowers inputs in ascending order
// [RQ11] mode lasts until standby power cycles
// [RQ12] test port dead once chain enabled
// [RQ13] test logic reset selects identification register
// [RQ14] identification register 32 bits, lsb one
// [RQ15] low twelve id bits never end marker
// [RQ16] eleven id bits hold manufacturer number
// [RQ17] bypass is one stage capturing zero
// [RQ18] host discovers via data scan after reset
// [RQ19] host shifts eight ones then zeros
// [RQ20] zero bit counts a port without id
// [RQ21] one bit starts a 32-bit id
module xcp_chain_test #(
   parameter int          NUM_PINS  = 8,
   parameter logic [10:0] MFR_ID    = 11'h2A5,   // arbitrary value
   parameter logic [15:0] PART_ID   = 16'h1234,  // arbitrary value
   parameter logic [3:0]  VERSION   = 4'h1       // arbitrary value
) (
   input  wire logic                clk,
   input  wire logic                nrst,
   input  wire logic                tck,
   input  wire logic                tms,
   input  wire logic                tdi,
   input  wire logic                trst_n,
   output logic                     tdo,
   output logic                     tdo_oe,
   input  wire logic [NUM_PINS-1:0] pad_in,
   output logic      [NUM_PINS-1:0] pad_out,
   output logic      [NUM_PINS-1:0] pad_oe,
   input  wire logic [NUM_PINS-1:0] core_out,
   input  wire logic [NUM_PINS-1:0] core_oe,
   output logic      [NUM_PINS-1:0] core_in,
   input  wire logic                result_core_out,
   output logic                     chain_result_pin,
   output logic                     chain_active
);
   localparam logic [31:0] ID_VALUE = {VERSION, PART_ID, MFR_ID, 1'b1}; // see [RQ14] [RQ16]

   // refuse widths and codes the logic cannot serve, at elaboration
   if (NUM_PINS < 1) begin : g_bad_pins
      $error("NUM_PINS must be at least one");
   end
   if (ID_VALUE[11:0] == xcp_pkg::END_MARKER) begin : g_bad_id // see [RQ15]
      $error("id low bits hit end marker");
   end

   // test port state
   xcp_pkg::xcp_tap_type     state_reg;
   logic [xcp_pkg::IR_LEN-1:0] ir_reg, ir_shift_reg;
   logic [31:0]              dr_shift_reg, test4_reg, rst_test_reg;
   logic                     chain_en_reg, tdo_reg, result_reg;
   logic [xcp_pkg::SYNC_STAGES-1:0] tck_s, tms_s, tdi_s, trst_s;
   logic [NUM_PINS-1:0]      pad_s1, pad_s2;
   logic                     tck_prev, tck_rise, tck_fall;

   // every pin passes two flops before logic reads it
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tck_s  <= '0;
         tms_s  <= '1;
         tdi_s  <= '0;
         trst_s <= '0;
         pad_s1 <= '0;
         pad_s2 <= '0;
      end else begin
         tck_s  <= {tck_s[0], tck};
         tms_s  <= {tms_s[0], tms};
         tdi_s  <= {tdi_s[0], tdi};
         trst_s <= {trst_s[0], trst_n};
         pad_s1 <= pad_in;
         pad_s2 <= pad_s1;
      end
   end

   // edge detect on the settled test clock
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) tck_prev <= 1'b0;
      else       tck_prev <= tck_s[1];
   end
   assign tck_rise = tck_s[1] & ~tck_prev;
   assign tck_fall = ~tck_s[1] & tck_prev;

   // standard controller walk on tms
   function automatic xcp_pkg::xcp_tap_type tap_next(input xcp_pkg::xcp_tap_type s,
                                                     input logic m);
      case (s)
         xcp_pkg::TLR:    tap_next = m ? xcp_pkg::TLR    : xcp_pkg::RTI;
         xcp_pkg::RTI:    tap_next = m ? xcp_pkg::SEL_DR : xcp_pkg::RTI;
         xcp_pkg::SEL_DR: tap_next = m ? xcp_pkg::SEL_IR : xcp_pkg::CAP_DR;
         xcp_pkg::CAP_DR: tap_next = m ? xcp_pkg::EX1_DR : xcp_pkg::SH_DR;
         xcp_pkg::SH_DR:  tap_next = m ? xcp_pkg::EX1_DR : xcp_pkg::SH_DR;
         xcp_pkg::EX1_DR: tap_next = m ? xcp_pkg::UPD_DR : xcp_pkg::PA_DR;
         xcp_pkg::PA_DR:  tap_next = m ? xcp_pkg::EX2_DR : xcp_pkg::PA_DR;
         xcp_pkg::EX2_DR: tap_next = m ? xcp_pkg::UPD_DR : xcp_pkg::SH_DR;
         xcp_pkg::UPD_DR: tap_next = m ? xcp_pkg::SEL_DR : xcp_pkg::RTI;
         xcp_pkg::SEL_IR: tap_next = m ? xcp_pkg::TLR    : xcp_pkg::CAP_IR;
         xcp_pkg::CAP_IR: tap_next = m ? xcp_pkg::EX1_IR : xcp_pkg::SH_IR;
         xcp_pkg::SH_IR:  tap_next = m ? xcp_pkg::EX1_IR : xcp_pkg::SH_IR;
         xcp_pkg::EX1_IR: tap_next = m ? xcp_pkg::UPD_IR : xcp_pkg::PA_IR;
         xcp_pkg::PA_IR:  tap_next = m ? xcp_pkg::EX2_IR : xcp_pkg::PA_IR;
         xcp_pkg::EX2_IR: tap_next = m ? xcp_pkg::UPD_IR : xcp_pkg::SH_IR;
         xcp_pkg::UPD_IR: tap_next = m ? xcp_pkg::SEL_DR : xcp_pkg::RTI;
         default:         tap_next = xcp_pkg::TLR;
      endcase
   endfunction

   // controller state; frozen for good once the chain is on
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)                  state_reg <= xcp_pkg::TLR;
      else if (chain_en_reg)      state_reg <= state_reg;                 // see [RQ12]
      else if (!trst_s[1])        state_reg <= xcp_pkg::TLR;
      else if (tck_rise)          state_reg <= tap_next(state_reg, tms_s[1]);
   end

   // instruction path
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ir_reg       <= xcp_pkg::IR_IDCODE;
         ir_shift_reg <= '0;
      end else if (!chain_en_reg && tck_rise) begin
         case (state_reg)
            xcp_pkg::TLR:    ir_reg <= xcp_pkg::IR_IDCODE;                // see [RQ13]
            xcp_pkg::CAP_IR: ir_shift_reg <= xcp_pkg::IR_CAPTURE;
            xcp_pkg::SH_IR:  ir_shift_reg <= {tdi_s[1], ir_shift_reg[xcp_pkg::IR_LEN-1:1]};
            xcp_pkg::UPD_IR: ir_reg <= ir_shift_reg;
            default:         ir_reg <= ir_reg;
         endcase
      end
   end

   // data path: capture, shift and update per selected register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dr_shift_reg <= '0;
         test4_reg    <= xcp_pkg::TEST4_RESET;
         rst_test_reg <= xcp_pkg::TEST4_RESET;
      end else if (!chain_en_reg && tck_rise) begin
         case (state_reg)
            xcp_pkg::CAP_DR: begin
               case (ir_reg)
                  xcp_pkg::IR_IDCODE:   dr_shift_reg <= ID_VALUE;         // see [RQ14]
                  xcp_pkg::IR_TEST4:    dr_shift_reg <= test4_reg;
                  xcp_pkg::IR_RST_TEST: dr_shift_reg <= rst_test_reg;
                  default:              dr_shift_reg <= '0;               // see [RQ17]
               endcase
            end
            xcp_pkg::SH_DR: begin
               if (ir_reg == xcp_pkg::IR_IDCODE || ir_reg == xcp_pkg::IR_TEST4 ||
                   ir_reg == xcp_pkg::IR_RST_TEST)
                  dr_shift_reg <= {tdi_s[1], dr_shift_reg[31:1]};
               else
                  dr_shift_reg <= {31'h00000000, tdi_s[1]};               // see [RQ17]
            end
            xcp_pkg::UPD_DR: begin
               if (ir_reg == xcp_pkg::IR_TEST4)
                  test4_reg <= dr_shift_reg & xcp_pkg::TEST4_WMASK;       // see [RQ1]
               else if (ir_reg == xcp_pkg::IR_RST_TEST)
                  rst_test_reg <= dr_shift_reg & xcp_pkg::RST_TEST_WMASK;
            end
            default: dr_shift_reg <= dr_shift_reg;
         endcase
      end
   end

   // chain enable is sticky; only reset (standby power cycle) clears it
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         chain_en_reg <= 1'b0;                                            // see [RQ11]
      else if (tck_rise && state_reg == xcp_pkg::UPD_DR && ir_reg == xcp_pkg::IR_TEST4 &&
               dr_shift_reg[xcp_pkg::CHAIN_EN_BIT])
         chain_en_reg <= 1'b1;                                            // see [RQ2]
   end

   // serial output changes on the falling test clock
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)                       tdo_reg <= 1'b0;
      else if (tck_fall && state_reg == xcp_pkg::SH_IR) tdo_reg <= ir_shift_reg[0];
      else if (tck_fall && state_reg == xcp_pkg::SH_DR) tdo_reg <= dr_shift_reg[0];
   end
   assign tdo    = tdo_reg;
   assign tdo_oe = !chain_en_reg &&
                   (state_reg == xcp_pkg::SH_IR || state_reg == xcp_pkg::SH_DR); // see [RQ12]

   // inverted parity of all chain pins; one extra flop keeps glitches off the pin
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)             result_reg <= 1'b0;
      else if (chain_en_reg) result_reg <= ~^pad_s2;                      // see [RQ6] [RQ7] [RQ8]
      else                   result_reg <= result_core_out;
   end
   assign chain_result_pin = result_reg;                                  // see [RQ5]
   assign chain_active     = chain_en_reg;

   // excluded pins never reach this block; chain pins detached in chain mode
   genvar g;
   generate
      for (g = 0; g < NUM_PINS; g++) begin : g_pad
         assign pad_out[g] = chain_en_reg ? 1'b0 : core_out[g];           // see [RQ3] [RQ4]
         assign pad_oe[g]  = chain_en_reg ? 1'b0 : core_oe[g];
         assign core_in[g] = chain_en_reg ? 1'b0 : pad_s2[g];
      end
   endgenerate

   AST_CHAIN_STICKY: assert property (@(posedge clk) disable iff (!nrst) // see [RQ11]
      chain_en_reg |=> chain_en_reg) else $error("chain mode dropped");
   AST_RESULT_XNOR: assert property (@(posedge clk) disable iff (!nrst) // see [RQ8]
      chain_en_reg && $past(chain_en_reg, 3) |-> result_reg == ~^$past(pad_in, 3))
      else $error("result not inverted parity of pins");
   AST_TOGGLE: assert property (@(posedge clk) disable iff (!nrst) // see [RQ6]
      chain_en_reg && $past(chain_en_reg, 4) &&
      $countones($past(pad_in, 3) ^ $past(pad_in, 4)) == 1
      |-> result_reg != $past(result_reg)) else $error("single change did not toggle");
   AST_DETACH: assert property (@(posedge clk) disable iff (!nrst) // see [RQ3]
      chain_en_reg |-> pad_oe == '0 && core_in == '0) else $error("pin not detached");
   AST_PORT_DEAD: assert property (@(posedge clk) disable iff (!nrst) // see [RQ12]
      chain_en_reg |=> !tdo_oe && $stable(state_reg) && $stable(ir_reg))
      else $error("test port active in chain mode");
   AST_TLR_IDCODE: assert property (@(posedge clk) disable iff (!nrst) // see [RQ13]
      !chain_en_reg && tck_rise && state_reg == xcp_pkg::TLR |=> ir_reg == xcp_pkg::IR_IDCODE)
      else $error("reset state did not select id");
   AST_ID_CAPTURE: assert property (@(posedge clk) disable iff (!nrst) // see [RQ14]
      !chain_en_reg && tck_rise && state_reg == xcp_pkg::CAP_DR && ir_reg == xcp_pkg::IR_IDCODE
      |=> dr_shift_reg[0] && dr_shift_reg[11:0] != xcp_pkg::END_MARKER)
      else $error("bad id capture");
   AST_BYPASS_ZERO: assert property (@(posedge clk) disable iff (!nrst) // see [RQ17]
      !chain_en_reg && tck_rise && state_reg == xcp_pkg::CAP_DR && ir_reg == xcp_pkg::IR_BYPASS
      |=> dr_shift_reg[0] == 1'b0) else $error("bypass did not capture zero");
   AST_ENABLE: assert property (@(posedge clk) disable iff (!nrst) // see [RQ2]
      tck_rise && state_reg == xcp_pkg::UPD_DR && ir_reg == xcp_pkg::IR_TEST4
      |=> chain_en_reg == ($past(chain_en_reg) || $past(dr_shift_reg[1])))
      else $error("enable bit misread");

   COV_CHAIN_ON: cover property (@(posedge clk) disable iff (!nrst) $rose(chain_en_reg));
   COV_ID_READ: cover property (@(posedge clk) disable iff (!nrst)
      tck_rise && state_reg == xcp_pkg::CAP_DR && ir_reg == xcp_pkg::IR_IDCODE);
   COV_BYPASS: cover property (@(posedge clk) disable iff (!nrst)
      tck_rise && state_reg == xcp_pkg::SH_DR && ir_reg == xcp_pkg::IR_BYPASS);
   COV_TOGGLE: cover property (@(posedge clk) disable iff (!nrst)
      chain_en_reg && $changed(result_reg));
endmodule

// File: verif/xcp_tap_host.sv
// board-side host model driving the test port pins
module xcp_tap_host (
   input  wire logic clk,
   input  wire logic tdo,
   input  wire logic tdo_oe,
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   output logic      trst_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // tck idles low between frames
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
      trst_n = 1'b1;
   end
   // one tck period; 5 clk cycles per tck half clear the pin synchronisers
   task automatic step(input logic m, input logic d, output logic q);
      @(posedge clk);
      #1;
      tms = m;
      tdi = d;
      repeat (5) @(posedge clk);
      #1;
      q = tdo_oe ? tdo : ~tdo; // released pin reads inverted, so a late enable shows
      tck = 1'b1;
      repeat (5) @(posedge clk);
      #1 tck = 1'b0;
   endtask
   // pin pulse plus five tms ones, so reset holds even if the pin is ignored
   task automatic to_reset();
      logic q;
      @(posedge clk);
      #1 trst_n = 1'b0;
      repeat (5) @(posedge clk);
      #1 trst_n = 1'b1;
      repeat (5) step(1'b1, 1'b0, q);
   endtask
   // scan n bits lsb first from idle back to idle; no ir step unless asked
   task automatic scan(input logic ir, input int n, input logic [63:0] din,
                       output logic [63:0] dout);
      logic q;
      dout = '0;
      step(1'b0, 1'b0, q);
      step(1'b1, 1'b0, q);
      if (ir) step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
      step(1'b0, 1'b0, q);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      step(1'b1, 1'b0, q);
      step(1'b0, 1'b0, q);
   endtask
endmodule

// File: verif/xcp_chain_test_tb.sv
// self-checking bench for the pin continuity chain and its test port
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin errors++; \
   $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module xcp_chain_test_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int          NP  = 8;
   localparam logic [10:0] MFR = 11'h3C5;   // arbitrary value
   localparam logic [15:0] PRT = 16'hA61E;  // arbitrary value
   localparam logic [3:0]  VER = 4'h6;      // arbitrary value
   logic          clk, nrst, tck, tms, tdi, trst_n, tdo, tdo_oe, rco, crp, act, ex, oe_hi, oe_bad;
   logic [NP-1:0] pad_in, pad_out, pad_oe, core_out, core_oe, core_in;
   logic [63:0]   dout;
   logic [7:0]    d;
   logic [31:0]   w;
   int            errors, checks, cyc;
   xcp_chain_test #(.NUM_PINS(NP), .MFR_ID(MFR), .PART_ID(PRT), .VERSION(VER)) u_xcp_chain_test (
      .clk(clk), .nrst(nrst), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo),
      .tdo_oe(tdo_oe), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
      .core_out(core_out), .core_oe(core_oe), .core_in(core_in), .result_core_out(rco),
      .chain_result_pin(crp), .chain_active(act));
   xcp_tap_host u_xcp_tap_host (.clk(clk), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms),
      .tdi(tdi), .trst_n(trst_n));
   // expected identification word
   function automatic logic [31:0] id_exp();
      return {VER, PRT, MFR, 1'b1};
   endfunction
   task automatic print_verdict();
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // watchdog and serial enable watchers; sampling off the edge avoids races
   always @(negedge clk) begin
      cyc++;
      if (tdo_oe === 1'b1 && act === 1'b0) oe_hi = 1'b1;
      if (tdo_oe !== 1'b0 && act === 1'b1) oe_bad = 1'b1;
      if (cyc == 40000) begin
         errors++;
         print_verdict();
      end
   end
   // main sequence; counters start at zero by default, only the watchdog drives cyc
   initial begin
      {nrst, rco, oe_hi, oe_bad, pad_in, core_out, core_oe} = '0;
      void'($urandom(17));
      wait_clk(10);
      `CHK("act rst", 1'b0, act)
      nrst = 1'b1;
      repeat (12) begin
         {core_out, core_oe, pad_in, rco} = {NP'($urandom()), NP'($urandom()), NP'($urandom()),
            1'($urandom())};
         wait_clk(5);
         `CHK("pad_out", core_out, pad_out)
         `CHK("pad_oe", core_oe, pad_oe)
         `CHK("core_in", pad_in, core_in)
         `CHK("result", rco, crp)
      end
      u_xcp_tap_host.to_reset();
      // long enough that the id is followed by the whole end marker
      u_xcp_tap_host.scan(1'b0, 64, 64'hFF, dout);
      `CHK("idcode", id_exp(), dout[31:0])
      `CHK("id end", 1'b1, dout[11:0] !== xcp_pkg::END_MARKER)
      `CHK("mfr", MFR, dout[11:1])
      `CHK("chain end", 32'h000000FF, dout[63:32])
      // a documented and an unassigned code both give bypass
      for (int k = 0; k < 2; k++) begin
         u_xcp_tap_host.scan(1'b1, 4, 64'(k ? 4'h7 : xcp_pkg::IR_BYPASS), dout);
         `CHK("ir capture", xcp_pkg::IR_CAPTURE, dout[3:0])
         d = 8'($urandom());
         u_xcp_tap_host.scan(1'b0, 9, 64'(d), dout);
         `CHK("bypass", {d, 1'b0}, dout[8:0])
      end
      `CHK("tdo_oe shift", 1'b1, oe_hi)
      // reset test register keeps its writable bits; its bit 1 never starts the chain
      w = $urandom() | 32'h00000002;
      u_xcp_tap_host.scan(1'b1, 4, 64'(xcp_pkg::IR_RST_TEST), dout);
      u_xcp_tap_host.scan(1'b0, 32, 64'(w), dout);
      `CHK("rst test reset", xcp_pkg::TEST4_RESET, dout[31:0])
      u_xcp_tap_host.scan(1'b0, 32, 64'h0, dout);
      `CHK("rst test read", w & xcp_pkg::RST_TEST_WMASK, dout[31:0])
      `CHK("rst test no chain", 1'b0, act)
      u_xcp_tap_host.scan(1'b1, 4, 64'(xcp_pkg::IR_TEST4), dout);
      u_xcp_tap_host.scan(1'b0, 32, 64'h1D, dout);
      wait_clk(3);
      `CHK("mode off", 1'b0, act)
      u_xcp_tap_host.scan(1'b0, 32, 64'h2, dout);
      `CHK("test4 read", 32'h1D & xcp_pkg::TEST4_WMASK, dout[31:0])
      pad_in = '0;
      wait_clk(5);
      `CHK("mode on", 1'b1, act)
      `CHK("chain low", 1'b1, crp)
      ex = 1'b1;
      // raise descending, then lower ascending; each step flips the result
      for (int s = 0; s < 2 * NP; s++) begin
         pad_in[s < NP ? NP - 1 - s : s - NP] = s < NP;
         ex = ~ex;
         wait_clk(5);
         `CHK("toggle", ex, crp)
      end
      `CHK("chain final", 1'b1, crp)
      repeat (12) begin
         {pad_in, core_out, core_oe} = {NP'($urandom()), NP'($urandom()), NP'($urandom())};
         wait_clk(5);
         `CHK("xnor", ~^pad_in, crp)
         `CHK("detach", '0, {pad_out, pad_oe, core_in})
      end
      u_xcp_tap_host.to_reset();
      u_xcp_tap_host.scan(1'b1, 4, 64'(xcp_pkg::IR_TEST4), dout);
      u_xcp_tap_host.scan(1'b0, 32, 64'h0, dout);
      wait_clk(3);
      `CHK("sticky", 1'b1, act)
      `CHK("tdo_oe dead", 1'b0, oe_bad)
      nrst = 1'b0;
      wait_clk(2);
      nrst = 1'b1;
      wait_clk(4);
      `CHK("power cycle", 1'b0, act)
      `CHK("pad_oe back", core_oe, pad_oe)
      u_xcp_tap_host.to_reset();
      u_xcp_tap_host.scan(1'b0, 32, 64'hFF, dout);
      `CHK("port back", id_exp(), dout[31:0])
      print_verdict();
   end
endmodule
